//--- hw/ts_sample_pkg.sv
// constants for the third and fourth timestamp sample record
// Overview of operation
// - unit index pointer selects shown unit
// - nanoseconds bit 30 set on rising edge
// - third sample polarity flag, read-only, resets zero
// - third sample nanoseconds in bits 29:0
// - third sample seconds, full 32 bits
// - fourth sample polarity flag, read-only, resets zero
// - fourth sample nanoseconds in bits 29:0
// - fourth sample seconds, full 32 bits
// - third sample 8ns slot in bits 2:0
// - fourth sample 8ns slot in bits 2:0
// - slot codes 000,001,101,011,100 per 8ns
package ts_sample_pkg;

  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [15:0] OFS_S3_NS  = 16'h056C;
  localparam logic [15:0] OFS_S3_SEC = 16'h0570;
  localparam logic [15:0] OFS_S3_PH  = 16'h0574;
  localparam logic [15:0] OFS_S4_NS  = 16'h0578;
  localparam logic [15:0] OFS_S4_SEC = 16'h057C;
  localparam logic [15:0] OFS_S4_PH  = 16'h0580;
  localparam logic [15:0] OFS_CTRL   = 16'h0600;

  // field layout
  localparam int NS_W     = 30;
  localparam int SEC_W    = 32;
  localparam int SLOT_W   = 3;
  localparam int POL_BIT  = 30;
  localparam int UIDX_W   = 1;
  localparam int CTRL_EN  = 0;
  localparam int CTRL_CLR = 1;

  // reset values
  localparam logic [29:0] NS_RST   = 30'h0000_0000;
  localparam logic [31:0] SEC_RST  = 32'h0000_0000;
  localparam logic [2:0]  CODE_RST = 3'h0;
  localparam logic        POL_RST  = 1'h0;
  localparam logic        EN_RST   = 1'h1;

  // slot codes within the 40ns period
  localparam logic [2:0] CODE_0NS  = 3'h0;
  localparam logic [2:0] CODE_8NS  = 3'h1;
  localparam logic [2:0] CODE_16NS = 3'h5;
  localparam logic [2:0] CODE_24NS = 3'h3;
  localparam logic [2:0] CODE_32NS = 3'h4;

  // sample selector in the record index on the read side
  localparam logic SEL_THIRD  = 1'h0;
  localparam logic SEL_FOURTH = 1'h1;

endpackage

//--- hw/capture_record.sv
// one sample record: polarity, nanoseconds, seconds and slot code
`timescale 1ns/1ps
module capture_record (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // control
  input  wire logic        load_i,
  input  wire logic        clear_i,
  // captured values
  input  wire logic        pol_i,
  input  wire logic [29:0] nanos_i,
  input  wire logic [31:0] secs_i,
  input  wire logic [2:0]  code_i,
  // held record
  output logic             pol_o,
  output logic      [29:0] nanos_o,
  output logic      [31:0] secs_o,
  output logic      [2:0]  code_o
);

  // load beats clear, all fields move on one edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pol_o   <= ts_sample_pkg::POL_RST;
      nanos_o <= ts_sample_pkg::NS_RST;
      secs_o  <= ts_sample_pkg::SEC_RST;
      code_o  <= ts_sample_pkg::CODE_RST;
    end else if (load_i) begin
      pol_o   <= pol_i;
      nanos_o <= nanos_i;
      secs_o  <= secs_i;
      code_o  <= code_i;
    end else if (clear_i) begin
      pol_o   <= ts_sample_pkg::POL_RST;
      nanos_o <= ts_sample_pkg::NS_RST;
      secs_o  <= ts_sample_pkg::SEC_RST;
      code_o  <= ts_sample_pkg::CODE_RST;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_LOAD_ATOMIC: assert property (load_i |=>
    pol_o == $past(pol_i) && nanos_o == $past(nanos_i) &&
    secs_o == $past(secs_i) && code_o == $past(code_i))
    else $error("record fields not captured together");

  AST_CLEAR_ZERO: assert property (clear_i && !load_i |=>
    !pol_o && nanos_o == ts_sample_pkg::NS_RST && secs_o == ts_sample_pkg::SEC_RST &&
    code_o == ts_sample_pkg::CODE_RST)
    else $error("record not zero after clear");

endmodule

//--- hw/ts_sample_34.sv
// third and fourth event timestamp sample registers, per unit
`timescale 1ns/1ps
module ts_sample_34 #(
  parameter int UNITS = 2
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,

  // register port
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,

  // unit index pointer
  input  wire logic        unit_index_i,

  // capture from the trigger logic
  input  wire logic        cap_stb_i,
  input  wire logic        cap_unit_i,
  input  wire logic        cap_fourth_i,
  input  wire logic        cap_rising_i,
  input  wire logic [29:0] cap_nanos_i,
  input  wire logic [31:0] cap_secs_i,
  input  wire logic [2:0]  cap_slot_i,

  // status
  output logic             capture_enable_o
);

  localparam int REC = UNITS * 2;

  // elaboration check
  if (UNITS < 1 || UNITS > 2) begin : g_bad_units
    $error("UNITS must be 1 or 2");
  end

  // control register state
  logic             en_r;
  logic             clr;
  logic             ctrl_hit;

  // held records, index unit*2 + sample
  logic             pol_q   [REC];
  logic      [29:0] nanos_q [REC];
  logic      [31:0] sec_q   [REC];
  logic      [2:0]  code_q  [REC];

  // capture side
  logic      [2:0]  cap_code;
  logic             cap_go;

  // read side
  logic      [31:0] rdata_r;
  logic      [31:0] rdata_nxt;
  logic             sel_ok;
  logic      [1:0]  r3;
  logic      [1:0]  r4;

  // slot number to code
  function automatic logic [2:0] slot_code(input logic [2:0] slot);
    case (slot)
      3'h0: slot_code = ts_sample_pkg::CODE_0NS;
      3'h1: slot_code = ts_sample_pkg::CODE_8NS;
      3'h2: slot_code = ts_sample_pkg::CODE_16NS;
      3'h3: slot_code = ts_sample_pkg::CODE_24NS;
      3'h4: slot_code = ts_sample_pkg::CODE_32NS;
      default: slot_code = ts_sample_pkg::CODE_RST;
    endcase
  endfunction

  // control decode
  assign ctrl_hit = wr_i && (addr_i == ts_sample_pkg::OFS_CTRL);
  assign clr      = ctrl_hit && wdata_i[ts_sample_pkg::CTRL_CLR];

  // capture enable register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_r <= ts_sample_pkg::EN_RST;
    end else if (ctrl_hit) begin
      en_r <= wdata_i[ts_sample_pkg::CTRL_EN];
    end
  end

  assign capture_enable_o = en_r;

  // capture qualification
  assign cap_go   = cap_stb_i && en_r;
  assign cap_code = slot_code(cap_slot_i);

  // one record per unit and sample
  for (genvar i = 0; i < REC; i++) begin : g_rec
    logic load;

    assign load = cap_go && (int'(cap_unit_i) == i / 2) &&
                  (cap_fourth_i == ((i % 2) == 1));

    capture_record u_rec (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .load_i  (load),
      .clear_i (clr),
      .pol_i   (cap_rising_i),
      .nanos_i (cap_nanos_i),
      .secs_i  (cap_secs_i),
      .code_i  (cap_code),
      .pol_o   (pol_q[i]),
      .nanos_o (nanos_q[i]),
      .secs_o  (sec_q[i]),
      .code_o  (code_q[i])
    );
  end

  // record selection by unit index
  assign sel_ok = int'(unit_index_i) < UNITS;
  assign r3     = {unit_index_i, ts_sample_pkg::SEL_THIRD};
  assign r4     = {unit_index_i, ts_sample_pkg::SEL_FOURTH};

  // read data decode
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (sel_ok) begin
      case (addr_i)
        ts_sample_pkg::OFS_S3_NS: begin
          rdata_nxt[ts_sample_pkg::POL_BIT] = pol_q[r3];
          rdata_nxt[29:0] = nanos_q[r3];
        end
        ts_sample_pkg::OFS_S3_SEC: begin
          rdata_nxt = sec_q[r3];
        end
        ts_sample_pkg::OFS_S3_PH: begin
          rdata_nxt[2:0] = code_q[r3];
        end
        ts_sample_pkg::OFS_S4_NS: begin
          rdata_nxt[ts_sample_pkg::POL_BIT] = pol_q[r4];
          rdata_nxt[29:0] = nanos_q[r4];
        end
        ts_sample_pkg::OFS_S4_SEC: begin
          rdata_nxt = sec_q[r4];
        end
        ts_sample_pkg::OFS_S4_PH: begin
          rdata_nxt[2:0] = code_q[r4];
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
    if (addr_i == ts_sample_pkg::OFS_CTRL) begin
      rdata_nxt = 32'h0000_0000;
      rdata_nxt[ts_sample_pkg::CTRL_EN] = en_r;
    end
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence rd_at(logic [15:0] a, logic u);
    rd_i && addr_i == a && unit_index_i == u && !cap_stb_i && !clr;
  endsequence

  sequence cap_u0(logic fourth);
    cap_stb_i && en_r && cap_unit_i == 1'b0 && cap_fourth_i == fourth;
  endsequence

  AST_IDLE_ZERO: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data present without a read");

  AST_NS_RSVD: assert property (
    rd_i && (addr_i == ts_sample_pkg::OFS_S3_NS || addr_i == ts_sample_pkg::OFS_S4_NS)
    |=> !rdata_o[31])
    else $error("nanoseconds bit 31 not zero");

  AST_PH_RSVD: assert property (
    rd_i && (addr_i == ts_sample_pkg::OFS_S3_PH || addr_i == ts_sample_pkg::OFS_S4_PH)
    |=> rdata_o[31:3] == 29'h0000_0000)
    else $error("phase reserved bits not zero");

  AST_SEC3_READ: assert property (rd_at(ts_sample_pkg::OFS_S3_SEC, 1'b0)
    |=> rdata_o == $past(sec_q[0]))
    else $error("third seconds read mismatch");

  AST_POL4_RISE: assert property (cap_u0(1'b1) ##1
    rd_at(ts_sample_pkg::OFS_S4_NS, 1'b0)
    |=> rdata_o[30] == $past(cap_rising_i, 2))
    else $error("fourth polarity does not follow edge");

  AST_NS3_CAP: assert property (cap_u0(1'b0) ##1
    rd_at(ts_sample_pkg::OFS_S3_NS, 1'b0)
    |=> rdata_o[29:0] == $past(cap_nanos_i, 2) && rdata_o[30] == $past(cap_rising_i, 2))
    else $error("third nanoseconds not captured");

  AST_SEC4_CAP: assert property (cap_u0(1'b1) ##1
    rd_at(ts_sample_pkg::OFS_S4_SEC, 1'b0)
    |=> rdata_o == $past(cap_secs_i, 2))
    else $error("fourth seconds not captured");

  AST_NS4_CAP: assert property (cap_u0(1'b1) ##1
    rd_at(ts_sample_pkg::OFS_S4_NS, 1'b0)
    |=> rdata_o[29:0] == $past(cap_nanos_i, 2))
    else $error("fourth nanoseconds not captured");

  AST_SLOT3_16: assert property (cap_u0(1'b0) ##0 cap_slot_i == 3'h2 ##1
    rd_at(ts_sample_pkg::OFS_S3_PH, 1'b0)
    |=> rdata_o[2:0] == 3'h5)
    else $error("third slot code for 16ns wrong");

  AST_SLOT4_24: assert property (cap_u0(1'b1) ##0 cap_slot_i == 3'h3 ##1
    rd_at(ts_sample_pkg::OFS_S4_PH, 1'b0)
    |=> rdata_o[2:0] == 3'h3)
    else $error("fourth slot code for 24ns wrong");

  AST_SLOT3_8: assert property (cap_u0(1'b0) ##0 cap_slot_i == 3'h1 ##1
    rd_at(ts_sample_pkg::OFS_S3_PH, 1'b0)
    |=> rdata_o[2:0] == 3'h1)
    else $error("third slot code for 8ns wrong");

  AST_CAP_OFF: assert property (cap_stb_i && !en_r && !clr
    |=> $stable(sec_q[REC - 2]) && $stable(code_q[REC - 2]))
    else $error("record changed while capture disabled");

  AST_RO_WRITE: assert property (wr_i && addr_i == ts_sample_pkg::OFS_S3_SEC
    && !cap_stb_i |=> $stable(sec_q[0]))
    else $error("write changed a read-only record");

  AST_UNIT_SEL: assert property (rd_at(ts_sample_pkg::OFS_S3_SEC, 1'b1)
    |=> rdata_o == (UNITS > 1 ? $past(sec_q[REC - 2]) : 32'h0000_0000))
    else $error("second unit seconds not shown");

endmodule

//--- testbench/ts_sample_34_test.sv
// self-checking bench for the third and fourth sample record
`timescale 1ns/1ps
module ts_sample_34_test;
  logic        clk_i;
  logic        nrst_i;
  logic [15:0] addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        unit_index_i;
  logic        cap_stb_i;
  logic        cap_unit_i;
  logic        cap_fourth_i;
  logic        cap_rising_i;
  logic [29:0] cap_nanos_i;
  logic [31:0] cap_secs_i;
  logic [2:0]  cap_slot_i;
  logic        capture_enable_o;
  int          err_count;
  int          num_checks;
  logic        en_m;
  logic [31:0] m_ns  [2][2];
  logic [31:0] m_sec [2][2];
  logic [31:0] m_ph  [2][2];
  logic [15:0] ofs   [6];

  ts_sample_34 #(.UNITS(2)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .unit_index_i(unit_index_i), .cap_stb_i(cap_stb_i),
    .cap_unit_i(cap_unit_i), .cap_fourth_i(cap_fourth_i), .cap_rising_i(cap_rising_i),
    .cap_nanos_i(cap_nanos_i), .cap_secs_i(cap_secs_i), .cap_slot_i(cap_slot_i),
    .capture_enable_o(capture_enable_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // slot index to phase code
  function automatic logic [2:0] slot_code(input logic [2:0] idx);
    case (idx)
      3'h1:    return 3'h1;
      3'h2:    return 3'h5;
      3'h3:    return 3'h3;
      3'h4:    return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] exp_reg(input logic u, input logic [15:0] a);
    case (a)
      ts_sample_pkg::OFS_S3_NS:  return m_ns[u][0];
      ts_sample_pkg::OFS_S3_SEC: return m_sec[u][0];
      ts_sample_pkg::OFS_S3_PH:  return m_ph[u][0];
      ts_sample_pkg::OFS_S4_NS:  return m_ns[u][1];
      ts_sample_pkg::OFS_S4_SEC: return m_sec[u][1];
      ts_sample_pkg::OFS_S4_PH:  return m_ph[u][1];
      default:                   return 32'h0000_0000;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check32(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic read_chk(input logic u, input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_i);
    unit_index_i <= u;
    addr_i       <= a;
    rd_i         <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check32($sformatf("read %h unit %0d", a, u), e, rdata_o);
  endtask

  task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic check_all();
    for (int u = 0; u < 2; u++) begin
      for (int i = 0; i < 6; i++) read_chk(u[0], ofs[i], exp_reg(u[0], ofs[i]));
    end
  endtask

  // strobe stays high so calls may follow back to back
  task automatic cap(input logic u, input logic f, input logic [2:0] sl);
    @(posedge clk_i);
    cap_stb_i    <= 1'b1;
    cap_unit_i   <= u;
    cap_fourth_i <= f;
    cap_rising_i <= $urandom;
    cap_nanos_i  <= $urandom;
    cap_secs_i   <= $urandom;
    cap_slot_i   <= sl;
    #1;
    if (en_m) begin
      m_ns[u][f]  = {1'b0, cap_rising_i, cap_nanos_i};
      m_sec[u][f] = cap_secs_i;
      m_ph[u][f]  = {29'h0, slot_code(sl)};
    end
  endtask

  task automatic cap_end();
    @(posedge clk_i);
    cap_stb_i <= 1'b0;
  endtask

  // capture, then read in the very next cycle
  task automatic cap_read(input logic u, input logic f, input logic [2:0] sl,
                          input logic [15:0] a);
    cap(u, f, sl);
    @(posedge clk_i);
    cap_stb_i    <= 1'b0;
    unit_index_i <= u;
    addr_i       <= a;
    rd_i         <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check32($sformatf("read after capture %h", a), exp_reg(u, a), rdata_o);
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    {nrst_i, wr_i, rd_i, unit_index_i, cap_stb_i, cap_unit_i, cap_fourth_i} = '0;
    {cap_rising_i, addr_i, wdata_i, cap_nanos_i, cap_secs_i, cap_slot_i} = '0;
    err_count  = 0;
    num_checks = 0;
    en_m       = 1'b1;
    ofs = '{ts_sample_pkg::OFS_S3_NS, ts_sample_pkg::OFS_S3_SEC, ts_sample_pkg::OFS_S3_PH,
            ts_sample_pkg::OFS_S4_NS, ts_sample_pkg::OFS_S4_SEC, ts_sample_pkg::OFS_S4_PH};
    foreach (m_ns[u, f]) {m_ns[u][f], m_sec[u][f], m_ph[u][f]} = '0;
    void'($urandom(15469));
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1 check1("capture enable", 1'b1, capture_enable_o);
    check_all();
    // slot indices 0 to 7 once each, two per record, back to back, checked per group of four
    for (int s = 0; s < 8; s++) begin
      cap(s[1], s[0], s[2:0]);
      if (s % 4 == 3) begin
        cap_end();
        check_all();
      end
    end
    for (int k = 0; k < 30; k++) begin
      cap($urandom, $urandom, $urandom_range(0, 4));
      cap($urandom, $urandom, $urandom_range(0, 4));
      cap_end();
      check_all();
    end
    // read straight after capture
    cap_read(1'b0, 1'b0, 3'h2, ts_sample_pkg::OFS_S3_PH);
    cap_read(1'b0, 1'b1, 3'h3, ts_sample_pkg::OFS_S4_PH);
    cap_read(1'b0, 1'b0, 3'h1, ts_sample_pkg::OFS_S3_PH);
    cap_read(1'b0, 1'b0, 3'h4, ts_sample_pkg::OFS_S3_NS);
    cap_read(1'b0, 1'b1, 3'h4, ts_sample_pkg::OFS_S4_NS);
    cap_read(1'b0, 1'b1, 3'h0, ts_sample_pkg::OFS_S4_SEC);
    cap_read(1'b1, 1'b0, 3'h1, ts_sample_pkg::OFS_S3_SEC);
    // read-only records ignore writes
    for (int i = 0; i < 6; i++) write_reg(ofs[i], 32'hFFFF_FFFF);
    check_all();
    read_chk(1'b0, 16'h0100, 32'h0000_0000);
    // disabled capture leaves records alone
    write_reg(ts_sample_pkg::OFS_CTRL, 32'h0000_0000);
    check1("capture enable", 1'b0, capture_enable_o);
    en_m = 1'b0;
    cap(1'b1, 1'b0, 3'h2);
    cap_end();
    check_all();
    // clear all records and enable again
    write_reg(ts_sample_pkg::OFS_CTRL, 32'h0000_0003);
    en_m = 1'b1;
    foreach (m_ns[u, f]) {m_ns[u][f], m_sec[u][f], m_ph[u][f]} = '0;
    check1("capture enable", 1'b1, capture_enable_o);
    check_all();
    read_chk(1'b0, ts_sample_pkg::OFS_CTRL, 32'h0000_0001);
    // mid-run reset restores every default
    cap(1'b0, 1'b1, 3'h4);
    cap_end();
    write_reg(ts_sample_pkg::OFS_CTRL, 32'h0000_0000);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (m_sec[u, f]) {m_ns[u][f], m_sec[u][f], m_ph[u][f]} = '0;
    #1 check1("capture enable", 1'b1, capture_enable_o);
    check_all();
    tally_and_finish();
  end
endmodule
